// File: src/alarm_pkg.sv
// Purpose: Constants and carriers for the per-channel alarm mask/status block
// Assumes: 25 MHz system clock, 11-bit byte address, 8-bit register data
// Notes:   Offsets are per-channel low address bits; channels repeat every 40H
package alarm_pkg;

   // ************************************************************
   // Geometry
   // ************************************************************
   localparam int          NUM_CHAN       = 17;
   localparam logic [10:0] CH0_STAT_ONE   = 11'h7DF;

   // ************************************************************
   // Register offsets inside a channel
   // ************************************************************
   localparam logic [5:0]  OFS_MASK_ZERO  = 6'h1B;
   localparam logic [5:0]  OFS_MASK_ONE   = 6'h1C;
   localparam logic [5:0]  OFS_MASK_TWO   = 6'h1D;
   localparam logic [5:0]  OFS_STAT_ZERO  = 6'h1E;
   localparam logic [5:0]  OFS_STAT_ONE   = 6'h1F;
   localparam logic [5:0]  OFS_INT_ZERO   = 6'h20;
   localparam logic [5:0]  OFS_INT_ONE    = 6'h21;
   localparam logic [5:0]  OFS_EDGE_SEL   = 6'h22;
   localparam logic [5:0]  OFS_INT_TWO    = 6'h23;

   // ************************************************************
   // Reset values and implemented-bit masks
   // ************************************************************
   localparam logic [7:0]  MASK_ZERO_RST  = 8'hFF;
   localparam logic [7:0]  MASK_ONE_RST   = 8'hEF;
   localparam logic [7:0]  MASK_TWO_RST   = 8'h3F;
   localparam logic [7:0]  EDGE_SEL_RST   = 8'h00;
   localparam logic [7:0]  STAT_RST       = 8'h00;
   localparam logic [7:0]  INT_RST        = 8'h00;
   localparam logic [7:0]  MASK_TWO_BITS  = 8'h3F;
   localparam logic [7:0]  EDGE_SEL_BITS  = 8'h7F;
   localparam logic [7:0]  INT_ZERO_BITS  = 8'h1F;
   localparam logic [7:0]  INT_ONE_BITS   = 8'hE3;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int          CLK_HZ         = 25_000_000;
   localparam int          TICK_MS        = 1;
   localparam int          TICK_CYCLES    = CLK_HZ / 1000 * TICK_MS;
   localparam logic [12:0] ACT_MS         = 13'h0028;
   localparam logic [12:0] DEACT_T1_MS    = 13'h0028;
   localparam logic [12:0] DEACT_E1_MS    = 13'h001E;
   localparam logic [12:0] AUTO_LOOP_MS   = 13'h13EC;

   // ************************************************************
   // Carriers
   // ************************************************************
   typedef struct packed {
      logic        auto_loopback_state;
      logic        tx_overcurrent_state;
      logic        tx_clock_missing_state;
      logic        tx_signal_loss_state;
      logic        sys_signal_loss_state;
      logic        line_signal_loss_state;
      logic        sys_alarm_ind_state;
      logic        line_alarm_ind_state;
      logic        pattern_sync_state;
      logic        activate_code_seen;
      logic        deactivate_code_seen;
      logic        auto_loopback_enable;
      logic        e1_mode;
      logic        sys_bipolar_violation;
      logic        line_bipolar_violation;
      logic        sys_excess_zeros;
      logic        line_excess_zeros;
      logic        pattern_error;
      logic        error_count_overflow;
   } chan_in_t;

   typedef struct packed {
      logic [10:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } reg_req_t;

endpackage : alarm_pkg

// File: src/line_channel_alarm_mask_status.sv
// Purpose: Per-channel alarm status, interrupt latches and masks
// Assumes: Detector levels and event pulses are synchronous to clk
// Notes:   Channel 0 exposes only its second status register

module line_channel_alarm_mask_status #(
   parameter int NUM_CHAN    = alarm_pkg::NUM_CHAN,
   parameter int TICK_CYCLES = alarm_pkg::TICK_CYCLES
) (
   input  wire logic                clk,
   input  wire logic                resetn,
   input  alarm_pkg::reg_req_t      req,
   output logic [7:0]               rdata,
   input  alarm_pkg::chan_in_t      chan [NUM_CHAN],
   output logic                     irq
);

   // ************************************************************
   // Address match
   // ************************************************************
   function automatic logic hit(input logic [10:0] a, input int c,
                                input logic [5:0] o);
      logic [3:0] blk;
      blk = 4'(c - 1);
      if (c == 0) begin
         hit = (o == alarm_pkg::OFS_STAT_ONE) &&
               (a == alarm_pkg::CH0_STAT_ONE);
      end else begin
         hit = (a == {1'b0, blk, o});
      end
   endfunction : hit

   // ************************************************************
   // Millisecond tick
   // ************************************************************
   logic [31:0] tick_cnt_q;
   wire         tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));

   always_ff @(posedge clk) begin
      if (!resetn || tick) begin
         tick_cnt_q <= 32'h0000_0000;
      end else begin
         tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
      end
   end

   // ************************************************************
   // Channel state
   // ************************************************************
   logic [7:0]  mask0_q [NUM_CHAN];
   logic [7:0]  mask1_q [NUM_CHAN];
   logic [7:0]  mask2_q [NUM_CHAN];
   logic [7:0]  edge_q  [NUM_CHAN];
   logic [7:0]  alarm_status_zero_q [NUM_CHAN];
   logic [7:0]  alarm_status_one_q [NUM_CHAN];
   logic [7:0]  int0_q  [NUM_CHAN];
   logic [7:0]  int1_q  [NUM_CHAN];
   logic [7:0]  int2_q  [NUM_CHAN];
   logic [12:0] act_q   [NUM_CHAN];
   logic [12:0] deact_q [NUM_CHAN];
   logic [7:0]  rv      [NUM_CHAN];
   logic [NUM_CHAN-1:0] pend;

   for (genvar c = 0; c < NUM_CHAN; c++) begin : g_ch
      alarm_pkg::chan_in_t ci;
      logic [12:0] act_thr;
      logic [12:0] deact_thr;
      logic        act_on;
      logic        deact_on;
      logic [7:0]  alarm_status_zero_d;
      logic [7:0]  alarm_status_one_d;
      logic [7:0]  any0;
      logic [7:0]  any1;
      logic [7:0]  set0;
      logic [7:0]  set1;
      logic [7:0]  set2;
      logic [7:0]  clr0;
      logic [7:0]  clr1;
      logic [7:0]  clr2;
      logic [12:0] act_d;
      logic [12:0] deact_d;
      logic        wr_m0;
      logic        wr_m1;
      logic        wr_m2;
      logic        wr_es;

      assign ci = chan[c];

      // Code persistence qualifiers
      assign act_thr = ci.auto_loopback_enable ?
                       alarm_pkg::AUTO_LOOP_MS : alarm_pkg::ACT_MS;
      assign deact_thr = ci.auto_loopback_enable ? alarm_pkg::AUTO_LOOP_MS :
                         ci.e1_mode ? alarm_pkg::DEACT_E1_MS :
                         alarm_pkg::DEACT_T1_MS;
      assign act_on   = (act_q[c] > act_thr);
      assign deact_on = (deact_q[c] > deact_thr);
      assign act_d   = !ci.activate_code_seen ? 13'h0000 :
                       (tick && !act_on) ? act_q[c] + 13'h0001 : act_q[c];
      assign deact_d = !ci.deactivate_code_seen ? 13'h0000 :
                       (tick && !deact_on) ? deact_q[c] + 13'h0001 :
                       deact_q[c];

      // Live status images
      assign alarm_status_zero_d = {ci.auto_loopback_state, 2'b00,
                        ci.tx_overcurrent_state,
                        ci.tx_clock_missing_state, ci.tx_signal_loss_state,
                        ci.sys_signal_loss_state,
                        ci.line_signal_loss_state};
      assign alarm_status_one_d = {ci.sys_alarm_ind_state, ci.line_alarm_ind_state,
                        ci.pattern_sync_state, 3'b000,
                        act_on, deact_on};

      // Latch set terms
      assign any0 = {3'b000, edge_q[c][4], edge_q[c][3], edge_q[c][2],
                     edge_q[c][1], edge_q[c][1]};
      assign any1 = {edge_q[c][6], edge_q[c][6], edge_q[c][5], 3'b000,
                     edge_q[c][0], edge_q[c][0]};
      assign set0 = ((alarm_status_zero_d & ~alarm_status_zero_q[c]) |
                     ((alarm_status_zero_d ^ alarm_status_zero_q[c]) & any0)) &
                    alarm_pkg::INT_ZERO_BITS;
      assign set1 = ((alarm_status_one_d & ~alarm_status_one_q[c]) |
                     ((alarm_status_one_d ^ alarm_status_one_q[c]) & any1)) &
                    alarm_pkg::INT_ONE_BITS;
      assign set2 = {2'b00, ci.sys_bipolar_violation,
                     ci.line_bipolar_violation, ci.sys_excess_zeros,
                     ci.line_excess_zeros, ci.pattern_error,
                     ci.error_count_overflow};

      // Write decode
      assign wr_m0 = req.wr && hit(req.addr, c, alarm_pkg::OFS_MASK_ZERO);
      assign wr_m1 = req.wr && hit(req.addr, c, alarm_pkg::OFS_MASK_ONE);
      assign wr_m2 = req.wr && hit(req.addr, c, alarm_pkg::OFS_MASK_TWO);
      assign wr_es = req.wr && hit(req.addr, c, alarm_pkg::OFS_EDGE_SEL);
      assign clr0 = (req.wr && hit(req.addr, c, alarm_pkg::OFS_INT_ZERO)) ?
                    req.wdata : 8'h00;
      assign clr1 = (req.wr && hit(req.addr, c, alarm_pkg::OFS_INT_ONE)) ?
                    req.wdata : 8'h00;
      assign clr2 = (req.wr && hit(req.addr, c, alarm_pkg::OFS_INT_TWO)) ?
                    req.wdata : 8'h00;

      always_ff @(posedge clk) begin
         if (!resetn) begin
            mask0_q[c] <= alarm_pkg::MASK_ZERO_RST;
            mask1_q[c] <= alarm_pkg::MASK_ONE_RST;
            mask2_q[c] <= alarm_pkg::MASK_TWO_RST;
            edge_q[c]  <= alarm_pkg::EDGE_SEL_RST;
         end else begin
            if (wr_m0) begin
               mask0_q[c] <= req.wdata;
            end
            if (wr_m1) begin
               mask1_q[c] <= req.wdata;
            end
            if (wr_m2) begin
               mask2_q[c] <= req.wdata & alarm_pkg::MASK_TWO_BITS;
            end
            if (wr_es) begin
               edge_q[c] <= req.wdata & alarm_pkg::EDGE_SEL_BITS;
            end
         end
      end

      // Set wins over a clear in the same cycle
      always_ff @(posedge clk) begin
         if (!resetn) begin
            alarm_status_zero_q[c] <= alarm_pkg::STAT_RST;
            alarm_status_one_q[c] <= alarm_pkg::STAT_RST;
            int0_q[c]  <= alarm_pkg::INT_RST;
            int1_q[c]  <= alarm_pkg::INT_RST;
            int2_q[c]  <= alarm_pkg::INT_RST;
            act_q[c]   <= 13'h0000;
            deact_q[c] <= 13'h0000;
         end else begin
            alarm_status_zero_q[c] <= alarm_status_zero_d;
            alarm_status_one_q[c] <= alarm_status_one_d;
            int0_q[c]  <= (int0_q[c] & ~clr0) | set0;
            int1_q[c]  <= (int1_q[c] & ~clr1) | set1;
            int2_q[c]  <= (int2_q[c] & ~clr2) | set2;
            act_q[c]   <= act_d;
            deact_q[c] <= deact_d;
         end
      end

      // Unmasked pending events of this channel
      assign pend[c] = |(int0_q[c] & ~mask0_q[c]) |
                       |(int1_q[c] & ~mask1_q[c]) |
                       |(int2_q[c] & ~mask2_q[c]);

      // Read selection
      assign rv[c] =
         (hit(req.addr, c, alarm_pkg::OFS_MASK_ZERO) ? mask0_q[c] : 8'h00) |
         (hit(req.addr, c, alarm_pkg::OFS_MASK_ONE)  ? mask1_q[c] : 8'h00) |
         (hit(req.addr, c, alarm_pkg::OFS_MASK_TWO)  ? mask2_q[c] : 8'h00) |
         (hit(req.addr, c, alarm_pkg::OFS_STAT_ZERO) ? alarm_status_zero_q[c] : 8'h00) |
         (hit(req.addr, c, alarm_pkg::OFS_STAT_ONE)  ? alarm_status_one_q[c] : 8'h00) |
         (hit(req.addr, c, alarm_pkg::OFS_INT_ZERO)  ? int0_q[c]  : 8'h00) |
         (hit(req.addr, c, alarm_pkg::OFS_INT_ONE)   ? int1_q[c]  : 8'h00) |
         (hit(req.addr, c, alarm_pkg::OFS_EDGE_SEL)  ? edge_q[c]  : 8'h00) |
         (hit(req.addr, c, alarm_pkg::OFS_INT_TWO)   ? int2_q[c]  : 8'h00);
   end

   // ************************************************************
   // Read port and interrupt output
   // ************************************************************
   logic [7:0] rd_all;

   always_comb begin
      rd_all = 8'h00;
      for (int c = 0; c < NUM_CHAN; c++) begin
         rd_all = rd_all | rv[c];
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         rdata <= 8'h00;
         irq   <= 1'b0;
      end else begin
         rdata <= req.rd ? rd_all : 8'h00;
         irq   <= |pend;
      end
   end

endmodule : line_channel_alarm_mask_status

// File: bench/alarm_props.sv
// Purpose: Port assertions for the alarm mask/status block
// Assumes: Channels 0 and 1 carry the checked traffic
// Notes:   Code timer bounds allow two ticks of slack
module alarm_props #(
   parameter int NUM_CHAN    = 17,
   parameter int TICK_CYCLES = 4
) (
   input wire logic           clk,
   input wire logic           resetn,
   input alarm_pkg::reg_req_t req,
   input wire logic [7:0]     rdata,
   input alarm_pkg::chan_in_t chan [NUM_CHAN],
   input wire logic           irq
);
   // ********
   // Helpers
   // ********
   alarm_pkg::chan_in_t [NUM_CHAN-1:0] all, all_q;
   alarm_pkg::chan_in_t c1;
   logic [7:0] st0, sq1;
   logic       chg, rd_s0, rd_z1, rd_1f, wr_1c, rd_1c, wr_1d, rd_1d;
   int         cnt_a, cnt_d, thr_a, thr_d;
   for (genvar i = 0; i < NUM_CHAN; i++) begin : g_all
      assign all[i] = chan[i];
   end
   assign c1 = chan[1];
   assign chg = all != all_q;
   assign st0 = {c1.auto_loopback_state, 2'b00, c1.tx_overcurrent_state,
      c1.tx_clock_missing_state, c1.tx_signal_loss_state,
      c1.sys_signal_loss_state, c1.line_signal_loss_state};
   assign sq1 = {chan[0].sys_alarm_ind_state, chan[0].line_alarm_ind_state,
      chan[0].pattern_sync_state, 5'b00000};
   assign rd_s0 = req.rd && req.addr == 11'h01E;
   assign rd_z1 = req.rd && req.addr == 11'h7DF;
   assign rd_1f = req.rd && req.addr == 11'h01F;
   assign wr_1c = req.wr && req.addr == 11'h01C;
   assign rd_1c = req.rd && req.addr == 11'h01C;
   assign wr_1d = req.wr && req.addr == 11'h01D;
   assign rd_1d = req.rd && req.addr == 11'h01D;
   assign thr_a = (c1.auto_loopback_enable ? 5100 : 40) * TICK_CYCLES;
   assign thr_d = (c1.auto_loopback_enable ? 5100 :
                   c1.e1_mode ? 30 : 40) * TICK_CYCLES;
   always_ff @(posedge clk) begin
      all_q <= all;
      cnt_a <= (resetn && c1.activate_code_seen) ? cnt_a + 1 : 0;
      cnt_d <= (resetn && c1.deactivate_code_seen) ? cnt_d + 1 : 0;
   end
   // ********
   // Properties
   // ********
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence s_m1; wr_1c ##2 rd_1c; endsequence
   sequence s_m2; wr_1d ##2 rd_1d; endsequence
   property p_idle; rdata != 8'h00 |-> $past(req.rd); endproperty
   a_idle: assert property (p_idle) else $error("rdata without read");
   property p_st0;
      $past(resetn) && rd_s0 && $stable(st0) |=> rdata == $past(st0);
   endproperty
   a_st0: assert property (p_st0) else $error("status zero wrong");
   property p_sq1;
      $past(resetn) && rd_z1 && $stable(sq1) |=> rdata[7:2] == $past(sq1[7:2]);
   endproperty
   a_sq1: assert property (p_sq1) else $error("ch0 status wrong");
   property p_m1; s_m1 |=> rdata == $past(req.wdata, 3); endproperty
   a_m1: assert property (p_m1) else $error("mask one readback");
   property p_m2; s_m2 |=> rdata == ($past(req.wdata, 3) & 8'h3F); endproperty
   a_m2: assert property (p_m2) else $error("mask two readback");
   property p_up;
      $rose(irq) |-> $past(chg) || $past(chg, 2) || $past(req.wr) ||
         $past(req.wr, 2) || $past(c1.activate_code_seen, 3) ||
         $past(c1.deactivate_code_seen, 3);
   endproperty
   a_up: assert property (p_up) else $error("irq rose without cause");
   property p_dn; $fell(irq) |-> $past(req.wr, 2); endproperty
   a_dn: assert property (p_dn) else $error("irq fell without write");
   property p_act;
      rd_1f |=> (!rdata[1] || $past(cnt_a) >= thr_a) &&
         ($past(cnt_a) < thr_a + 2 * TICK_CYCLES + 3 || rdata[1]);
   endproperty
   a_act: assert property (p_act) else $error("activate timing");
   property p_dea;
      rd_1f |=> (!rdata[0] || $past(cnt_d) >= thr_d) &&
         ($past(cnt_d) < thr_d + 2 * TICK_CYCLES + 3 || rdata[0]);
   endproperty
   a_dea: assert property (p_dea) else $error("deactivate timing");
endmodule : alarm_props

bind line_channel_alarm_mask_status alarm_props #(.NUM_CHAN(NUM_CHAN),
   .TICK_CYCLES(TICK_CYCLES)) u_props (.clk(clk), .resetn(resetn),
   .req(req), .rdata(rdata), .chan(chan), .irq(irq));

// File: bench/line_channel_alarm_mask_status_test.sv
// Purpose: Self-checking bench for the alarm mask/status block
// Assumes: Code tick shortened to four clocks
// Notes:   Channel 1 carries most stimulus
module line_channel_alarm_mask_status_test;
   timeunit 1ns;
   timeprecision 1ns;
   // ********
   // Design and stimulus
   // ********
   localparam int       TK = 4;
   logic                clk = 1'b0;
   logic                resetn = 1'b0;
   alarm_pkg::reg_req_t req = '0;
   logic [7:0]          rdata;
   alarm_pkg::chan_in_t chan [17] = '{default: '0};
   logic                irq;
   int                  mismatches = 0;
   int                  check_count = 0;
   always #20 clk = ~clk;
   line_channel_alarm_mask_status #(.NUM_CHAN(17), .TICK_CYCLES(TK)) u_dut (
      .clk(clk), .resetn(resetn), .req(req), .rdata(rdata), .chan(chan),
      .irq(irq));
   // ********
   // Tasks
   // ********
   task automatic cmp(input string n, input logic [7:0] e, g);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s exp %h got %h", n, e, g);
      end
   endtask : cmp
   task automatic wr(input logic [10:0] a, input logic [7:0] d);
      @(posedge clk);
      req.wr <= 1'b1;
      req.addr <= a;
      req.wdata <= d;
      @(posedge clk);
      req.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [10:0] a, input logic [7:0] e);
      @(posedge clk);
      req.rd <= 1'b1;
      req.addr <= a;
      @(posedge clk);
      req.rd <= 1'b0;
      #1 cmp($sformatf("reg %h", a), e, rdata);
   endtask : rd
   task automatic chk_irq(input logic [7:0] e);
      repeat (3) @(posedge clk);
      #1 cmp("irq", e, {7'h00, irq});
   endtask : chk_irq
   task automatic pulse(input int b);
      @(posedge clk);
      chan[1] <= chan[1] | (19'h00001 << b);
      @(posedge clk);
      chan[1] <= chan[1] & ~(19'h00001 << b);
   endtask : pulse
   task automatic code(input logic [18:0] v, input int lo, hi,
                       input logic [7:0] e);
      @(posedge clk);
      chan[1] <= '0;
      repeat (4) @(posedge clk);
      chan[1] <= v;
      repeat (lo * TK) @(posedge clk);
      rd(11'h01F, 8'h00);
      repeat ((hi - lo) * TK) @(posedge clk);
      rd(11'h01F, e);
   endtask : code
   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : final_report
   // ********
   // Tests
   // ********
   initial begin
      #1600000;
      mismatches++;
      final_report();
   end
   initial begin
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      rd(11'h01C, 8'hEF);
      rd(11'h01D, 8'h3F);
      rd(11'h01E, 8'h00);
      rd(11'h01F, 8'h00);
      rd(11'h3DC, 8'hEF);
      rd(11'h01A, 8'h00);
      wr(11'h01C, 8'h12);
      rd(11'h01C, 8'h12);
      wr(11'h01D, 8'hFF);
      rd(11'h01D, 8'h3F);
      wr(11'h01E, 8'hFF);
      rd(11'h01E, 8'h00);
      wr(11'h01C, 8'hFF);
      $display("test registers done");
      @(posedge clk);
      chan[1] <= 19'h7FC00;
      chan[16] <= 19'h40000;
      chan[0] <= 19'h01000;
      rd(11'h01E, 8'h9F);
      rd(11'h01F, 8'hE0);
      rd(11'h3DE, 8'h80);
      rd(11'h3DF, 8'h00);
      rd(11'h7DF, 8'h80);
      rd(11'h7DE, 8'h00);
      $display("test status done");
      chk_irq(8'h00);
      wr(11'h01C, 8'h7F);
      chk_irq(8'h01);
      wr(11'h01C, 8'hFF);
      chk_irq(8'h00);
      wr(11'h01C, 8'hDF);
      chk_irq(8'h01);
      wr(11'h021, 8'h00);
      chk_irq(8'h01);
      wr(11'h021, 8'hE0);
      chk_irq(8'h00);
      wr(11'h022, 8'h40);
      wr(11'h01C, 8'h7F);
      chk_irq(8'h00);
      @(posedge clk);
      chan[1].sys_alarm_ind_state <= 1'b0;
      chk_irq(8'h01);
      wr(11'h021, 8'h80);
      chk_irq(8'h00);
      wr(11'h022, 8'h00);
      wr(11'h01C, 8'hFF);
      for (int i = 0; i < 6; i++) begin
         wr(11'h01D, 8'h3F ^ (8'h01 << i));
         pulse((i + 1) % 6);
         chk_irq(8'h00);
         pulse(i);
         chk_irq(8'h01);
         wr(11'h023, 8'h3F);
         chk_irq(8'h00);
      end
      wr(11'h01D, 8'h3F);
      $display("test interrupts done");
      wr(11'h01C, 8'hFD);
      code(19'h00200, 38, 46, 8'h02);
      chk_irq(8'h01);
      wr(11'h01C, 8'hFF);
      wr(11'h021, 8'hFF);
      code(19'h00140, 28, 34, 8'h01);
      code(19'h00100, 36, 46, 8'h01);
      code(19'h00280, 5000, 5104, 8'h02);
      $display("test codes done");
      final_report();
   end
endmodule : line_channel_alarm_mask_status_test
